// ---- common/tta_pkg.sv ----
`default_nettype none
package tta_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int SLEEP_MS = 80;
  localparam int SLEEP_CYC = SLEEP_MS * (CLK_HZ / 1000);
  localparam int SEC_CYC = CLK_HZ;
  localparam int SUSTAIN_MS = 32;
  localparam int SUSTAIN_CYC = SUSTAIN_MS * (CLK_HZ / 1000);
  localparam int CANCEL_MS = 157;
  localparam int CANCEL_CYC = CANCEL_MS * (CLK_HZ / 1000);
  localparam logic [7:0] RECAL_S = 8'h3c;
  localparam logic [4:0] STRAP_CYC = 5'h10;
  localparam logic [16:0] THRESH = 17'h0000a;
  localparam logic [16:0] HYST = 17'h00002;
  localparam logic [2:0] DI_LAST = 3'h3;
  localparam logic [2:0] DRIFT_UP_DIV = 3'h7;
  localparam logic [17:0] BASE15_S = 18'h00384;
  localparam logic [17:0] BASE60_S = 18'h00e10;
  localparam logic [9:0] RC_STEP_S = 10'h00f;
  localparam logic [7:0] RC_MIN = 8'h04;
  localparam logic [7:0] RC_MAX = 8'hf0;
  localparam logic [4:0] MULT_HI = 5'h18;
  localparam logic signed [7:0] SPREAD_PM = 8'sh4b;
  localparam logic signed [7:0] SPREAD_STEP = 8'sh05;
  typedef enum logic [1:0] {
    TC_GND = 2'h0, TC_VDD = 2'h1, TC_OUT = 2'h2, TC_RC = 2'h3
  } tta_tcfg_t;
  typedef enum logic [4:0] {
    ST_INIT = 5'b00001,
    ST_CALW = 5'b00010,
    ST_SLEEP = 5'b00100,
    ST_MEAS = 5'b01000,
    ST_HOLD = 5'b10000
  } tta_state_t;
endpackage
`default_nettype wire

// ---- verilog/tta_top.sv ----
`default_nettype none
module tta_top #(
  parameter int SLEEP_CYC = tta_pkg::SLEEP_CYC,
  parameter int SEC_CYC = tta_pkg::SEC_CYC,
  parameter int SUSTAIN_CYC = tta_pkg::SUSTAIN_CYC,
  parameter int CANCEL_CYC = tta_pkg::CANCEL_CYC
) (
  // Clock and power-up reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Measurement front end
  output logic BURST_REQ,
  input wire logic SAMPLE_VALID,
  input wire logic [15:0] SAMPLE_DATA,
  output logic signed [7:0] OSC_DITHER,
  // Output pin and its polarity strap
  input wire logic OUT_PIN_I,
  output logic OUT_PIN_O,
  output logic OUT_PIN_OE_N,
  // Timeout strap classification
  input wire tta_pkg::tta_tcfg_t TIME_CFG,
  input wire logic [7:0] RC_COUNT,
  // Multiplier sense pin level
  input wire logic MULT_SENSE_PIN,
  // Status
  output logic OUTPUT_ON,
  output logic FAST_MODE
);
  import tta_pkg::*;

  tta_state_t st_q;
  logic [1:0] opin_s, mpin_s;
  logic [31:0] cnt_q, sec_cnt_q, dev_cnt_q;
  logic [4:0] strap_cnt_q;
  logic act_low_q, mult24_q, mult_ref_q, burst_q, on_q, pin_q, oe_n_q;
  tta_tcfg_t tcfg_q;
  logic [7:0] rc_q, recal_sec_q;
  logic [15:0] ref_q;
  logic [2:0] di_q, up_div_q;
  logic lat_q, dev_q, dir_q;
  logic signed [7:0] dith_q;
  logic [17:0] off_cnt_q, base_s, delay_s;
  logic inf_dly, tick, dev, meas_v, cal_v, det, release_lat, confirm;
  logic cancel, sustain, timeout, recal_pend, init_done;
  logic [16:0] samp_x, thr_lvl;

  // Pin synchronisers
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      opin_s <= 2'h0;
      mpin_s <= 2'h0;
    end else begin
      opin_s <= {opin_s[0], OUT_PIN_I};
      mpin_s <= {mpin_s[0], MULT_SENSE_PIN};
    end
  end

  assign init_done = (st_q == ST_INIT) && (strap_cnt_q == STRAP_CYC);

  // Strap capture after reset release
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      strap_cnt_q <= 5'h00;
      act_low_q <= 1'b0;
      mult24_q <= 1'b0;
      mult_ref_q <= 1'b0;
      tcfg_q <= TC_GND;
      rc_q <= 8'h00;
    end else if (st_q == ST_INIT) begin
      strap_cnt_q <= strap_cnt_q + 5'h01;
      if (init_done) begin
        act_low_q <= opin_s[1];
        mult24_q <= mpin_s[1];
        mult_ref_q <= mpin_s[1];
        tcfg_q <= TIME_CFG;
        rc_q <= RC_COUNT;
      end
    end
  end

  // Base delay in seconds and multiplier
  always_comb begin
    base_s = BASE60_S;
    inf_dly = 1'b0;
    case (tcfg_q)
      TC_GND: begin
        base_s = BASE15_S;
        inf_dly = !act_low_q;
      end
      TC_VDD: begin
        base_s = BASE15_S;
        inf_dly = act_low_q;
      end
      TC_OUT: base_s = BASE60_S;
      TC_RC: begin
        if (rc_q < RC_MIN) begin
          base_s = BASE60_S;
        end else if (rc_q > RC_MAX) begin
          inf_dly = 1'b1;
        end else begin
          base_s = 18'({10'h000, rc_q} * RC_STEP_S);
        end
      end
      default: base_s = BASE60_S;
    endcase
    delay_s = mult24_q ? 18'(base_s * MULT_HI) : base_s;
  end

  // One-second tick
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || sec_cnt_q == 32'(SEC_CYC - 1)) begin
      sec_cnt_q <= 32'h00000000;
    end else begin
      sec_cnt_q <= sec_cnt_q + 32'h00000001;
    end
  end
  assign tick = (sec_cnt_q == 32'(SEC_CYC - 1));

  // Override pulse measurement on multiplier strap
  assign dev = (st_q != ST_INIT) && (mpin_s[1] != mult_ref_q);
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      dev_q <= 1'b0;
      dev_cnt_q <= 32'h00000000;
    end else begin
      dev_q <= dev;
      if (!dev) begin
        dev_cnt_q <= 32'h00000000;
      end else if (dev_cnt_q != 32'(CANCEL_CYC)) begin
        dev_cnt_q <= dev_cnt_q + 32'h00000001;
      end
    end
  end
  assign cancel = dev && (dev_cnt_q == 32'(CANCEL_CYC - 1));
  assign sustain = dev_q && !dev && (dev_cnt_q >= 32'(SUSTAIN_CYC))
                   && (dev_cnt_q < 32'(CANCEL_CYC));

  // Detection and integrator
  assign meas_v = (st_q == ST_MEAS) && SAMPLE_VALID;
  assign cal_v = (st_q == ST_CALW) && SAMPLE_VALID;
  assign samp_x = {1'b0, SAMPLE_DATA};
  assign thr_lvl = {1'b0, ref_q} + THRESH;
  assign det = samp_x >= thr_lvl;
  assign release_lat = samp_x < (thr_lvl - HYST);
  assign confirm = meas_v && !lat_q && det && (di_q == DI_LAST);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ref_q <= 16'h0000;
      di_q <= 3'h0;
      lat_q <= 1'b0;
      up_div_q <= 3'h0;
    end else if (cal_v) begin
      ref_q <= SAMPLE_DATA;
      di_q <= 3'h0;
      lat_q <= 1'b0;
      up_div_q <= 3'h0;
    end else if (meas_v) begin
      if (lat_q) begin
        if (release_lat) begin
          lat_q <= 1'b0;
        end
      end else if (det) begin
        if (di_q == DI_LAST) begin
          di_q <= 3'h0;
          lat_q <= 1'b1;
        end else begin
          di_q <= di_q + 3'h1;
        end
      end else begin
        di_q <= 3'h0;
        if (di_q == 3'h0 && SAMPLE_DATA < ref_q) begin
          ref_q <= ref_q - 16'h0001;
        end else if (di_q == 3'h0 && SAMPLE_DATA > ref_q) begin
          up_div_q <= up_div_q + 3'h1;
          if (up_div_q == DRIFT_UP_DIV) begin
            ref_q <= ref_q + 16'h0001;
          end
        end
      end
    end
  end

  // Stuck detection timeout
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !lat_q) begin
      recal_sec_q <= 8'h00;
    end else if (tick && recal_sec_q != RECAL_S) begin
      recal_sec_q <= recal_sec_q + 8'h01;
    end
  end
  assign recal_pend = (recal_sec_q == RECAL_S);

  // Sequencer
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      st_q <= ST_INIT;
      cnt_q <= 32'h00000000;
      burst_q <= 1'b0;
    end else begin
      burst_q <= 1'b0;
      cnt_q <= cnt_q + 32'h00000001;
      case (st_q)
        ST_INIT: begin
          if (init_done) begin
            st_q <= ST_CALW;
            burst_q <= 1'b1;
          end
        end
        ST_CALW: begin
          if (SAMPLE_VALID) begin
            st_q <= ST_SLEEP;
            cnt_q <= 32'h00000000;
          end
        end
        ST_MEAS: begin
          if (SAMPLE_VALID) begin
            if (!lat_q && det && !confirm) begin
              burst_q <= 1'b1;
            end else begin
              st_q <= ST_SLEEP;
              cnt_q <= 32'h00000000;
            end
          end
        end
        ST_SLEEP: begin
          if (dev) begin
            st_q <= ST_HOLD;
          end else if (recal_pend) begin
            st_q <= ST_CALW;
            burst_q <= 1'b1;
          end else if (cnt_q >= 32'(SLEEP_CYC - 1)) begin
            st_q <= ST_MEAS;
            burst_q <= 1'b1;
          end
        end
        ST_HOLD: begin
          if (!dev) begin
            st_q <= ST_CALW;
            burst_q <= 1'b1;
          end
        end
        default: st_q <= ST_INIT;
      endcase
    end
  end

  // Output state and auto-off counter
  assign timeout = on_q && !inf_dly && tick && (off_cnt_q <= 18'h00001);
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      on_q <= 1'b0;
    end else if (cancel || timeout) begin
      on_q <= 1'b0;
    end else if (confirm) begin
      on_q <= !on_q;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      off_cnt_q <= 18'h00000;
    end else if ((confirm && !on_q) || (sustain && on_q)) begin
      off_cnt_q <= delay_s;
    end else if (on_q && !inf_dly && tick && off_cnt_q != 18'h00000) begin
      off_cnt_q <= off_cnt_q - 18'h00001;
    end
  end

  // Pin drive after strap read
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pin_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      pin_q <= on_q ^ act_low_q;
      oe_n_q <= (st_q == ST_INIT);
    end
  end

  // Spread-spectrum dither during bursts
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !(st_q == ST_MEAS || st_q == ST_CALW)) begin
      dith_q <= 8'sh00;
      dir_q <= 1'b0;
    end else if (!dir_q) begin
      dith_q <= dith_q + SPREAD_STEP;
      dir_q <= (dith_q + SPREAD_STEP) >= SPREAD_PM;
    end else begin
      dith_q <= dith_q - SPREAD_STEP;
      dir_q <= !((dith_q - SPREAD_STEP) <= -SPREAD_PM);
    end
  end

  assign BURST_REQ = burst_q;
  assign OSC_DITHER = dith_q;
  assign OUT_PIN_O = pin_q;
  assign OUT_PIN_OE_N = oe_n_q;
  assign OUTPUT_ON = on_q;
  assign FAST_MODE = (di_q != 3'h0);

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  property p_toggle;
    confirm && !cancel && !timeout |=> on_q != $past(on_q);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("confirmed touch did not toggle output");

  property p_pol;
    (st_q != ST_INIT) ##1 1 |-> OUT_PIN_O == $past(on_q ^ act_low_q);
  endproperty
  a_pol: assert property (p_pol)
    else $error("output pin polarity wrong");

  property p_di_clear;
    meas_v && !lat_q && !det |=> di_q == 3'h0;
  endproperty
  a_di_clear: assert property (p_di_clear)
    else $error("integrator not cleared on miss");

  property p_det_count;
    meas_v && !lat_q && det && di_q < DI_LAST |=> di_q == $past(di_q) + 3'h1;
  endproperty
  a_det_count: assert property (p_det_count)
    else $error("detecting sample not counted");

  property p_frozen;
    lat_q && !cal_v |=> $stable(ref_q);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("reference moved during detection");

  property p_down;
    meas_v && !lat_q && !det && di_q == 3'h0 && SAMPLE_DATA < ref_q
      |=> ref_q == $past(ref_q) - 16'h0001;
  endproperty
  a_down: assert property (p_down)
    else $error("reference did not step down");

  property p_cancel;
    cancel |=> !on_q ##1 !on_q;
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("cancel pulse did not switch off");

  property p_timeout;
    timeout |=> !on_q;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("auto-off expiry did not switch off");

  property p_load;
    $rose(on_q) |-> off_cnt_q == $past(delay_s);
  endproperty
  a_load: assert property (p_load)
    else $error("auto-off counter not loaded on turn-on");

  property p_hold;
    st_q == ST_HOLD |=> !BURST_REQ || !dev;
  endproperty
  a_hold: assert property (p_hold)
    else $error("burst started during override hold");

  property p_oe;
    st_q == ST_INIT |=> OUT_PIN_OE_N;
  endproperty
  a_oe: assert property (p_oe)
    else $error("output pin driven during strap read");

  c_confirm: cover property (confirm);
  c_cancel: cover property (cancel && on_q);
  c_recal: cover property (recal_pend ##[1:3] st_q == ST_CALW);
  c_timeout: cover property (timeout);
endmodule
`default_nettype wire

// ---- test/tta_touch_model.sv ----
`default_nettype none
module tta_touch_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic burst_req,
  input wire logic [1:0] lat,
  input wire logic [1:0] noise,
  output logic sample_valid,
  output logic [15:0] sample_data
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] BASE = 16'h03e8;
  localparam logic [15:0] LIFT = 16'h0014;
  int hot = 0;
  int wait_q = 0;
  // Samples count down from each burst request; released data toggles each cycle
  always @(posedge clk) begin
    sample_valid <= 1'b0;
    sample_data <= ~sample_data;
    if (!rst_n) begin
      wait_q <= 0;
      sample_data <= 16'h0000;
    end else if (burst_req) begin
      wait_q <= int'(lat) + 1;
    end else if (wait_q > 1) begin
      wait_q <= wait_q - 1;
    end else if (wait_q == 1) begin
      wait_q <= 0;
      sample_valid <= 1'b1;
      sample_data <= BASE + {14'h0000, noise} + ((hot > 0) ? LIFT : 16'h0);
      if (hot > 0) begin
        hot <= hot - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/tta_bench.sv ----
`default_nettype none
module tta_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import tta_pkg::*;
  localparam int SL = 20;
  localparam int SC = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mult = 1'b0;
  logic al = 1'b0;
  logic sv, oe_n, pin_o, on, fast, br, exp_on;
  logic [15:0] sd;
  logic signed [7:0] dith;
  logic [7:0] rc = 8'h00;
  logic [31:0] seed = 32'h123a1f33;
  tta_tcfg_t cfg = TC_GND;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int bursts = 0;
  int fast_seen = 0;
  wire logic pin_i;
  assign pin_i = oe_n ? al : pin_o;

  tta_top #(.SLEEP_CYC(SL), .SEC_CYC(SC), .SUSTAIN_CYC(8), .CANCEL_CYC(30))
    tta_top_i (.CORE_CLK(clk), .RST_N(rst_n), .BURST_REQ(br),
    .SAMPLE_VALID(sv), .SAMPLE_DATA(sd), .OSC_DITHER(dith),
    .OUT_PIN_I(pin_i), .OUT_PIN_O(pin_o), .OUT_PIN_OE_N(oe_n),
    .TIME_CFG(cfg), .RC_COUNT(rc), .MULT_SENSE_PIN(mult),
    .OUTPUT_ON(on), .FAST_MODE(fast));
  tta_touch_model tta_touch_model_i (.clk(clk), .rst_n(rst_n),
    .burst_req(br), .lat(seed[3:2]), .noise(seed[1:0]),
    .sample_valid(sv), .sample_data(sd));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int delay_s(logic a, tta_tcfg_t c, logic [7:0] r);
    case (c)
      TC_GND: return a ? 900 : 0;
      TC_VDD: return a ? 0 : 900;
      TC_OUT: return 3600;
      default: return (r < 8'd4) ? 3600 : ((r > 8'd240) ? 0 : int'(r) * 15);
    endcase
  endfunction

  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic do_reset(input logic a, input tta_tcfg_t c,
                          input logic [7:0] r);
    al = a;
    cfg = c;
    rc = r;
    mult = 1'b0;
    rst_n = 1'b0;
    tick(3);
    chk(oe_n, 1'b1);
    chk(on, 1'b0);
    rst_n = 1'b1;
    tick(60);
    chk(oe_n, 1'b0);
    chk(pin_o, a);
    exp_on = 1'b0;
  endtask

  // Feed n lifted samples then one plain one
  task automatic touch(input int n);
    int k;
    tta_touch_model_i.hot = n;
    fast_seen = 0;
    repeat (n + 1) begin
      k = 0;
      do begin
        tick(1);
        if (fast) fast_seen = 1;
        k++;
      end while (!sv && k < 300);
      if (k >= 300) errors++;
    end
    tick(3);
    exp_on ^= (n == 4);
  endtask

  task automatic wait_off(input int lim, output int k);
    k = 0;
    while (on && k < lim) begin
      tick(1);
      k++;
    end
  endtask

  initial forever #10 clk = ~clk;

  always @(posedge clk) begin
    seed <= lfsr(seed);
    cyc <= cyc + 1;
    if (sv) chk((dith >= -8'sd75) && (dith <= 8'sd75), 1'b1);
    if (cyc == 40000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    int k;
    int d;
    do_reset(1'b0, TC_GND, 8'h00);
    touch(4);
    chk(on, 1'b1);
    chk(pin_o, 1'b1);
    chk(fast_seen != 0, 1'b1);
    touch(3);
    chk(on, 1'b1);
    chk(fast, 1'b0);
    touch(4);
    chk(on, 1'b0);
    for (int i = 0; i < 8; i++) begin
      touch(int'(seed % 5));
      chk(on, exp_on);
    end
    $display("toggle test done");
    do_reset(1'b1, TC_RC, 8'h04);
    touch(4);
    chk(pin_o, 1'b0);
    d = delay_s(al, cfg, rc);
    wait_off(4000, k);
    chk(k >= (d - 1) * SC - 40 && k <= (d + 1) * SC, 1'b1);
    $display("auto-off test done");
    touch(4);
    tick(40 * SC);
    mult = 1'b1;
    tick(15);
    mult = 1'b0;
    tick(40 * SC);
    chk(on, 1'b1);
    wait_off(30 * SC, k);
    chk(on, 1'b0);
    $display("sustain test done");
    touch(4);
    mult = 1'b1;
    wait_off(300, k);
    chk(on, 1'b0);
    bursts = 0;
    repeat (40) begin
      tick(1);
      if (br) bursts++;
    end
    chk(bursts == 0, 1'b1);
    mult = 1'b0;
    tick(60);
    chk(on, 1'b0);
    touch(4);
    chk(on, 1'b1);
    $display("cancel test done");
    do_reset(1'b0, TC_GND, 8'h00);
    tta_touch_model_i.hot = 1000000;
    tick(3500);
    chk(on, 1'b1);
    tta_touch_model_i.hot = 0;
    tick(1500);
    chk(on, 1'b1);
    touch(4);
    chk(on, 1'b0);
    $display("recalibration test done");
    give_verdict();
  end
endmodule
`default_nettype wire
